// *** shared/bst_defs.vh ***
// constants for the boundary-scan test logic: states, codes, cell layout
// included by the tap controller, the scan top, the checker and the bench; definitions only
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// tap controller states, binary coded
`define BST_ST_W 4
`define BST_ST_RESET 4'h0
`define BST_ST_IDLE 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SHIFT_DR 4'h4
`define BST_ST_EXIT1_DR 4'h5
`define BST_ST_PAUSE_DR 4'h6
`define BST_ST_EXIT2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_IR 4'h9
`define BST_ST_CAP_IR 4'hA
`define BST_ST_SHIFT_IR 4'hB
`define BST_ST_EXIT1_IR 4'hC
`define BST_ST_PAUSE_IR 4'hD
`define BST_ST_EXIT2_IR 4'hE
`define BST_ST_UPD_IR 4'hF

// instruction register and codes
`define BST_IR_W 4
`define BST_IR_EXTEST 4'h0
`define BST_IR_IDCODE 4'h1
`define BST_IR_HIGHZ 4'h4
`define BST_IR_SAMPLE 4'h5
`define BST_IR_BYPASS 4'hF
`define BST_IR_CAPTURE 4'h1

// identification register fields
`define BST_ID_W 32
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MFR_W 11
`define BST_ID_LSB 1'b1

// functional pin counts
`define BST_NI 4
`define BST_NO 4
`define BST_NB 2

// boundary chain layout, cell 0 nearest the serial output
`define BST_POS_OUT 4
`define BST_POS_BIN 8
`define BST_POS_BOUT 10
`define BST_POS_BEN 12
`define BST_POS_DIS 14
`define BST_BSR_LEN 15

// synchroniser vector: tck, tms, tdi, trst_n, inputs, disable, bidirs
`define BST_SY_W 11
`define BST_SY_TCK 0
`define BST_SY_TMS 1
`define BST_SY_TDI 2
`define BST_SY_TRST 3
`define BST_SY_IN 4
`define BST_SY_DIS 8
`define BST_SY_BIO 9

`endif

// *** design/bst_tap_fsm.v ***
// sixteen-state test access port controller
// assumes tck_rise is a one-cycle pulse and tms, trst_n are synchronised
`timescale 1ns/1ns
`include "bst_defs.vh"

module bst_tap_fsm
(
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // sampled test port
  input wire tck_rise,
  input wire tms,
  input wire trst_n,
  // controller state
  output reg [`BST_ST_W-1:0] state_reg
);

  reg [`BST_ST_W-1:0] state_next;

  // transition table, steered by tms at each rising test clock
  always @*
  begin
    case (state_reg)
      `BST_ST_RESET: state_next = tms ? `BST_ST_RESET : `BST_ST_IDLE;
      `BST_ST_IDLE: state_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      `BST_ST_SEL_DR: state_next = tms ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
      `BST_ST_CAP_DR: state_next = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
      `BST_ST_SHIFT_DR:
        state_next = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
      `BST_ST_EXIT1_DR: state_next = tms ? `BST_ST_UPD_DR : `BST_ST_PAUSE_DR;
      `BST_ST_PAUSE_DR:
        state_next = tms ? `BST_ST_EXIT2_DR : `BST_ST_PAUSE_DR;
      `BST_ST_EXIT2_DR: state_next = tms ? `BST_ST_UPD_DR : `BST_ST_SHIFT_DR;
      `BST_ST_UPD_DR: state_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      `BST_ST_SEL_IR: state_next = tms ? `BST_ST_RESET : `BST_ST_CAP_IR;
      `BST_ST_CAP_IR: state_next = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
      `BST_ST_SHIFT_IR:
        state_next = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
      `BST_ST_EXIT1_IR: state_next = tms ? `BST_ST_UPD_IR : `BST_ST_PAUSE_IR;
      `BST_ST_PAUSE_IR:
        state_next = tms ? `BST_ST_EXIT2_IR : `BST_ST_PAUSE_IR;
      `BST_ST_EXIT2_IR: state_next = tms ? `BST_ST_UPD_IR : `BST_ST_SHIFT_IR;
      `BST_ST_UPD_IR: state_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      default: state_next = `BST_ST_RESET;
    endcase
  end

  // tms held high walks any state to reset within five edges
  always @(posedge clk_sys)
  begin
    if (sys_rst || !trst_n)
      state_reg <= `BST_ST_RESET;
    else if (tck_rise)
      state_reg <= state_next;
  end

endmodule

// *** design/bst_scan_top.v ***
// boundary-scan test logic: tap, instruction, bypass, id, boundary chain
// assumes the test port pins and functional pins are asynchronous to
// clk_sys; the test clock is sampled, so it must stay well below clk_sys/4
//
// Behaviour
// - instruction register four bits, shifted in shift-IR
// - code 0000 selects external test via chain
// - id code at update-IR selects id, normal pins
// - code 0100 floats outputs, bypass selected
// - code 0101 samples pins, preloads, core undisturbed
// - code 1111 selects one-bit bypass, normal pins
// - other codes select bypass and float outputs
// - capture-IR loads 0001
// - instruction resets to id code in reset
// - external test captures input pins at capture-DR
// - external test outputs change at update-DR fall
// - shift-DR moves selected register toward tdo
// - floating held until another instruction updates or the controller reaches reset
// - bypass captures zero at capture-DR
// - bypass leaves boundary update stage unchanged
// - bypass register is a single stage
// - id register 32 bits, loaded at capture-DR
// - id fields: version, part, maker, one
// - every functional pin has a boundary cell
// - disable input has cell, ignored in external test
// - sixteen-state controller moves on rising test clock
// - five tms-high edges reach reset
// - test reset low forces controller reset
`timescale 1ns/1ns
`include "bst_defs.vh"

module bst_scan_top
#(
  // identification fields, values arbitrary
  parameter [`BST_ID_VER_W-1:0] ID_VERSION = 4'hA,
  parameter [`BST_ID_PART_W-1:0] ID_PART = 16'h5A5A,
  parameter [`BST_ID_MFR_W-1:0] ID_MAKER = 11'h155
)
(
  // system clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // test access port
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe,
  // functional pins
  input wire [`BST_NI-1:0] pin_in,
  input wire pin_dis,
  output reg [`BST_NO-1:0] pin_out,
  output reg [`BST_NO-1:0] pin_out_oe,
  input wire [`BST_NB-1:0] pin_io_i,
  output reg [`BST_NB-1:0] pin_io_o,
  output reg [`BST_NB-1:0] pin_io_oe,
  // core side
  output reg [`BST_NI-1:0] core_in,
  output reg [`BST_NB-1:0] core_io_i,
  input wire [`BST_NO-1:0] core_out,
  input wire [`BST_NO-1:0] core_out_oe,
  input wire [`BST_NB-1:0] core_io_o,
  input wire [`BST_NB-1:0] core_io_oe
);

  // two-flop synchronisers for every asynchronous input
  reg [`BST_SY_W-1:0] sync1_reg;
  reg [`BST_SY_W-1:0] sync2_reg;
  reg tck_prev_reg;
  wire [`BST_SY_W-1:0] raw_in;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire trst_n_s;
  wire [`BST_NI-1:0] in_s;
  wire dis_s;
  wire [`BST_NB-1:0] bio_s;
  wire tck_rise;
  wire tck_fall;

  assign raw_in = {pin_io_i, pin_dis, pin_in, trst_n, tdi, tms, tck};

  // first stage is read only by the second stage
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1_reg <= {`BST_SY_W{1'b0}};
      sync2_reg <= {`BST_SY_W{1'b0}};
      tck_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      tck_prev_reg <= tck_s;
    end
  end

  assign tck_s = sync2_reg[`BST_SY_TCK];
  assign tms_s = sync2_reg[`BST_SY_TMS];
  assign tdi_s = sync2_reg[`BST_SY_TDI];
  assign trst_n_s = sync2_reg[`BST_SY_TRST] | sys_rst;
  assign in_s = sync2_reg[`BST_SY_DIS-1:`BST_SY_IN];
  assign dis_s = sync2_reg[`BST_SY_DIS];
  assign bio_s = sync2_reg[`BST_SY_W-1:`BST_SY_BIO];

  // edge strobes; both states sampled before the controller moves
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  // controller
  wire [`BST_ST_W-1:0] tap_state;

  bst_tap_fsm u_fsm
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tck_rise(tck_rise),
    .tms(tms_s),
    .trst_n(trst_n_s),
    .state_reg(tap_state)
  );

  wire st_reset = (tap_state == `BST_ST_RESET);
  wire st_cap_dr = (tap_state == `BST_ST_CAP_DR);
  wire st_sh_dr = (tap_state == `BST_ST_SHIFT_DR);
  wire st_upd_dr = (tap_state == `BST_ST_UPD_DR);
  wire st_cap_ir = (tap_state == `BST_ST_CAP_IR);
  wire st_sh_ir = (tap_state == `BST_ST_SHIFT_IR);
  wire st_upd_ir = (tap_state == `BST_ST_UPD_IR);

  // instruction shift stage and active instruction
  reg [`BST_IR_W-1:0] ir_shift_reg;
  reg [`BST_IR_W-1:0] ir_reg;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
      ir_shift_reg <= `BST_IR_CAPTURE;
    else if (tck_rise && st_cap_ir)
      ir_shift_reg <= `BST_IR_CAPTURE;
    else if (tck_rise && st_sh_ir)
      ir_shift_reg <= {tdi_s, ir_shift_reg[`BST_IR_W-1:1]};
  end

  // active code only moves at update-IR or in reset, so floating persists
  always @(posedge clk_sys)
  begin
    if (sys_rst || st_reset)
      ir_reg <= `BST_IR_IDCODE;
    else if (tck_fall && st_upd_ir)
      ir_reg <= ir_shift_reg;
  end

  // instruction decode
  reg sel_bsr;
  reg sel_id;
  reg test_mode;
  reg hiz_mode;

  always @*
  begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    test_mode = 1'b0;
    hiz_mode = 1'b0;
    case (ir_reg)
      `BST_IR_EXTEST:
      begin
        sel_bsr = 1'b1;
        test_mode = 1'b1;
      end
      `BST_IR_IDCODE: sel_id = 1'b1;
      `BST_IR_HIGHZ: hiz_mode = 1'b1;
      `BST_IR_SAMPLE: sel_bsr = 1'b1;
      `BST_IR_BYPASS: hiz_mode = 1'b0;
      default: hiz_mode = 1'b1;
    endcase
  end

  // bypass: one stage, zero captured first
  reg bypass_reg;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
      bypass_reg <= 1'b0;
    else if (tck_rise && st_cap_dr)
      bypass_reg <= 1'b0;
    else if (tck_rise && st_sh_dr)
      bypass_reg <= tdi_s;
  end

  // identification register, reloaded at every capture-DR while selected
  reg [`BST_ID_W-1:0] id_reg;
  wire [`BST_ID_W-1:0] id_code;

  assign id_code = {ID_VERSION, ID_PART, ID_MAKER,
    `BST_ID_LSB};

  always @(posedge clk_sys)
  begin
    if (sys_rst)
      id_reg <= id_code;
    else if (tck_rise && st_cap_dr && sel_id)
      id_reg <= id_code;
    else if (tck_rise && st_sh_dr && sel_id)
      id_reg <= {tdi_s, id_reg[`BST_ID_W-1:1]};
  end

  // boundary chain capture vector; output cells see what is driven
  wire [`BST_BSR_LEN-1:0] bsr_cap;
  reg [`BST_BSR_LEN-1:0] bsr_reg;
  reg [`BST_BSR_LEN-1:0] bsr_upd_reg;
  wire [`BST_BSR_LEN:0] bsr_chain;

  // every functional pin has a cell, disable input included
  assign bsr_cap = {dis_s, pin_io_oe, pin_io_o, bio_s, pin_out,
    in_s};
  assign bsr_chain = {tdi_s, bsr_reg};

  // one shift cell and one update cell per chain position
  genvar gi;
  generate
    for (gi = 0; gi < `BST_BSR_LEN; gi = gi + 1)
    begin : g_cell
      always @(posedge clk_sys)
      begin
        if (sys_rst)
          bsr_reg[gi] <= 1'b0;
        else if (tck_rise && st_cap_dr && sel_bsr)
          bsr_reg[gi] <= bsr_cap[gi];
        else if (tck_rise && st_sh_dr && sel_bsr)
          bsr_reg[gi] <= bsr_chain[gi+1];
      end

      // update stage only loads while the chain is selected
      always @(posedge clk_sys)
      begin
        if (sys_rst)
          bsr_upd_reg[gi] <= 1'b0;
        else if (tck_fall && st_upd_dr && sel_bsr)
          bsr_upd_reg[gi] <= bsr_reg[gi];
      end
    end
  endgenerate

  // serial output, launched on the falling test clock
  reg tdo_next;

  always @*
  begin
    if (st_sh_ir)
      tdo_next = ir_shift_reg[0];
    else if (sel_bsr)
      tdo_next = bsr_reg[0];
    else if (sel_id)
      tdo_next = id_reg[0];
    else
      tdo_next = bypass_reg;
  end

  // driver floats from the first falling test clock outside a shift state, at once in reset
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (st_reset)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= tdo_next;
      tdo_oe <= st_sh_ir | st_sh_dr;
    end
  end

  // pin muxing; update stage drives pins only in external test
  reg [`BST_NO-1:0] out_next;
  reg [`BST_NO-1:0] out_oe_next;
  reg [`BST_NB-1:0] io_next;
  reg [`BST_NB-1:0] io_oe_next;

  always @*
  begin
    out_next = core_out;
    out_oe_next = core_out_oe & {`BST_NO{~dis_s}};
    io_next = core_io_o;
    io_oe_next = core_io_oe & {`BST_NB{~dis_s}};
    if (hiz_mode)
    begin
      out_oe_next = {`BST_NO{1'b0}};
      io_oe_next = {`BST_NB{1'b0}};
    end
    else if (test_mode)
    begin
      // disable input ignored so update patterns stay intact
      out_next = bsr_upd_reg[`BST_POS_BIN-1:`BST_POS_OUT];
      out_oe_next = {`BST_NO{1'b1}};
      io_next = bsr_upd_reg[`BST_POS_BEN-1:`BST_POS_BOUT];
      io_oe_next = bsr_upd_reg[`BST_POS_DIS-1:`BST_POS_BEN];
    end
  end

  // pins registered; one clk_sys later than the update edge
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_out <= {`BST_NO{1'b0}};
      pin_out_oe <= {`BST_NO{1'b0}};
      pin_io_o <= {`BST_NB{1'b0}};
      pin_io_oe <= {`BST_NB{1'b0}};
    end
    else
    begin
      pin_out <= out_next;
      pin_out_oe <= out_oe_next;
      pin_io_o <= io_next;
      pin_io_oe <= io_oe_next;
    end
  end

  // core always sees the real pins; sampling never disturbs it
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      core_in <= {`BST_NI{1'b0}};
      core_io_i <= {`BST_NB{1'b0}};
    end
    else
    begin
      core_in <= in_s;
      core_io_i <= bio_s;
    end
  end

endmodule

// *** tb/bst_chk.sv ***
// assertion checker for the scan top, bound to its ports
// assumes tck is slow against clk_sys and stands low between frames
`timescale 1ns/1ns
`include "bst_defs.vh"

module bst_chk
(
  // watched ports
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [`BST_NO-1:0] pin_out,
  input wire logic [`BST_NO-1:0] pin_out_oe,
  input wire logic [`BST_NB-1:0] pin_io_oe
);
  logic tck_q;
  logic [3:0] idle_cnt;
  logic [2:0] hi_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // tck history: quiet time, and run of rises with tms high
  always @(posedge clk_sys)
  begin
    tck_q <= tck;
    if (sys_rst || tck != tck_q)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF)
      idle_cnt <= idle_cnt + 4'h1;
    if (sys_rst)
      hi_cnt <= 3'h0;
    else if (tck && !tck_q)
      hi_cnt <= !tms ? 3'h0 : (hi_cnt == 3'h5 ? hi_cnt : hi_cnt + 3'h1);
  end

  a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo enable moved while tck high");
  a_oe_span: assert property ($rose(tdo_oe) |-> tdo_oe [*7])
    else $error("tdo enable shorter than one shift");
  a_oe_needs_tck: assert property ($rose(tdo_oe) |-> idle_cnt < 4'h8)
    else $error("tdo enable rose without test clock");
  a_tms_five: assert property (hi_cnt == 3'h5 |-> !tdo_oe)
    else $error("tdo driven after five tms-high rises");
  a_trst_quiet: assert property (!trst_n [*4] |-> !tdo_oe)
    else $error("tdo driven during test reset");
  a_rst_tap: assert property (disable iff (1'b0)
    $past(sys_rst) |-> !tdo_oe && !tdo)
    else $error("tdo not quiet after reset");
  a_rst_pins: assert property (disable iff (1'b0)
    $past(sys_rst) |-> pin_out == 0 && pin_out_oe == 0 && pin_io_oe == 0)
    else $error("pins not quiet after reset");

  // main scenarios reached
  c_shift: cover property ($rose(tdo_oe));
  c_five: cover property (hi_cnt == 3'h5);
  c_float: cover property ($fell(pin_out_oe != 0));
endmodule

bind bst_scan_top bst_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .tck(tck), .tms(tms), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
  .pin_out(pin_out), .pin_out_oe(pin_out_oe), .pin_io_oe(pin_io_oe));

// *** tb/bst_tap_ctl.sv ***
// board test controller model: drives tck, tms, tdi and trst_n
// assumes the device samples on tck rise and answers after tck fall
`timescale 1ns/1ns

module bst_tap_ctl
(
  // test port toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // tck stands low between frames, as a real controller leaves it
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // one period: change after the fall, sample at the rise
  task automatic pulse(input logic m, input logic d, output logic [1:0] q);
    tms = m;
    tdi = d;
    #160;
    tck = 1'b1;
    // a floating tdo line reads as the inverse of the last value
    q = {tdo_oe, tdo_oe ? tdo : ~tdo};
    #160;
    tck = 1'b0;
  endtask

  // tms high on five rises, then settle in idle
  task automatic go_reset();
    logic [1:0] q;
    repeat (5) pulse(1'b1, tdi, q);
    pulse(1'b0, tdi, q);
    tdi = ~tdi;
  endtask

  // ir or dr scan from idle, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_ok);
    logic [1:0] q;
    dout = 32'h0;
    oe_ok = 1'b1;
    pulse(1'b1, tdi, q);
    if (ir)
      pulse(1'b1, tdi, q);
    pulse(1'b0, tdi, q);
    pulse(1'b0, tdi, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q[0];
      oe_ok = oe_ok & (q[1] === 1'b1);
    end
    pulse(1'b1, tdi, q);
    oe_ok = oe_ok & (q[1] === 1'b0);
    pulse(1'b0, tdi, q);
    tdi = ~tdi; // released line: no stale value
  endtask

  // test reset held low for five system clocks, then one step to idle
  task automatic hold_reset();
    logic [1:0] q;
    trst_n = 1'b0;
    #200;
    trst_n = 1'b1;
    #200;
    pulse(1'b0, tdi, q);
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the boundary-scan test logic
// assumes the checker is bound to the scan top and a controller model
`timescale 1ns/1ns
`include "bst_defs.vh"

module tb_top;
  // identification fields, values arbitrary
  localparam logic [31:0] ID_EXP = {4'h3, 16'h1234, 11'h2AB, 1'b1};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, pin_dis = 1'b0;
  logic [3:0] pin_in = 4'hC, pin_out, pin_out_oe, core_in;
  logic [3:0] core_out = 4'h9, core_out_oe = 4'h6;
  logic [1:0] pin_io_i, pin_io_o, pin_io_oe, core_io_i, io_ext = 2'h1;
  logic [1:0] core_io_o = 2'h1, core_io_oe = 2'h2;
  logic [31:0] got;
  logic oe;
  int err_count = 0;
  int num_checks = 0;

  // clock, and bidir wire level from both drivers
  always #20 clk_sys = ~clk_sys;
  assign pin_io_i = (pin_io_oe & pin_io_o) | (~pin_io_oe & io_ext);

  bst_scan_top #(.ID_VERSION(4'h3), .ID_PART(16'h1234), .ID_MAKER(11'h2AB))
  dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .pin_dis(pin_dis), .pin_out(pin_out),
    .pin_out_oe(pin_out_oe), .pin_io_i(pin_io_i), .pin_io_o(pin_io_o),
    .pin_io_oe(pin_io_oe), .core_in(core_in), .core_io_i(core_io_i),
    .core_out(core_out), .core_out_oe(core_out_oe), .core_io_o(core_io_o),
    .core_io_oe(core_io_oe));

  bst_tap_ctl ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic sc(input logic ir, input int n, input logic [31:0] din);
    ctl_u.scan(ir, n, din, got, oe);
    chk("tdo enable", oe, 1);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_id();
    sc(0, 32, 0);
    chk("id code", got, ID_EXP);
    chk("normal out", pin_out, core_out);
    $display("test id done");
  endtask

  task automatic t_bypass();
    sc(1, 4, 4'hF);
    chk("ir capture", got[3:0], 4'h1);
    sc(0, 8, 8'hB3);
    chk("bypass path", got[7:0], 8'h66);
    chk("bypass oe", pin_out_oe, core_out_oe);
    $display("test bypass done");
  endtask

  task automatic t_sample();
    @(negedge clk_sys);
    pin_dis = 1'b1;
    sc(1, 4, 4'h5);
    sc(0, 15, 15'h1A50);
    chk("sampled in", got[3:0], pin_in);
    chk("sampled out", got[7:4], core_out);
    chk("sampled dis", got[14], 1);
    chk("core undisturbed", pin_out, core_out);
    chk("core in", core_in, pin_in);
    chk("core io in", core_io_i, 2'h1);
    $display("test sample done");
  endtask

  task automatic t_extest();
    sc(1, 4, 4'h0);
    chk("preload out", pin_out, 4'h5);
    chk("dis ignored", pin_out_oe, 4'hF);
    chk("preload io", {pin_io_oe, pin_io_o}, 4'h6);
    @(negedge clk_sys);
    pin_in = 4'h3;
    sc(0, 15, 15'h0A30);
    chk("captured in", got[3:0], 4'h3);
    chk("captured out", got[7:4], 4'h5);
    chk("update out", pin_out, 4'h3);
    chk("update io oe", pin_io_oe, 2'h0);
    chk("update io", pin_io_o, 2'h2);
    $display("test extest done");
  endtask

  task automatic t_float();
    logic [11:0] codes;
    codes = 12'h824;
    @(negedge clk_sys);
    pin_dis = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      sc(1, 4, codes[4*k +: 4]);
      chk("float oe", {pin_out_oe, pin_io_oe}, 0);
      sc(0, 2, 2'h1);
      chk("float bypass", got[1:0], 2'h2);
      chk("float held", {pin_out_oe, pin_io_oe}, 0);
    end
    $display("test float done");
  endtask

  task automatic t_resets();
    sc(1, 4, 4'h1);
    chk("id oe", pin_out_oe, core_out_oe);
    sc(0, 32, 0);
    chk("id by code", got, ID_EXP);
    sc(1, 4, 4'h0);
    ctl_u.go_reset();
    chk("tms reset oe", pin_out_oe, core_out_oe);
    sc(0, 32, 0);
    chk("tms reset id", got, ID_EXP);
    sc(1, 4, 4'h4);
    ctl_u.hold_reset();
    sc(0, 32, 0);
    chk("trst id", got, ID_EXP);
    $display("test resets done");
  endtask

  // hang guard
  initial
  begin
    #2000000;
    err_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    // controller leaves reset for idle before the first scan
    ctl_u.go_reset();
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    t_float();
    t_resets();
    print_verdict();
  end
endmodule
